// File: design/scss_pkg.sv
package scss_pkg;

    // ==========================================================
    // Spare bit selection limits and acceptance
    // ==========================================================
    localparam logic [3:0] SPARE_BIT_MIN = 4'h4;
    localparam logic [3:0] SPARE_BIT_MAX = 4'h8;
    localparam logic [3:0] SPARE_BIT_OFS = 4'h1;
    localparam logic [1:0] ACCEPT_COUNT  = 2'h3;
    localparam logic [1:0] LAST_CODE_BIT = 2'h3;

    // ==========================================================
    // Status codes, most significant bit first
    // ==========================================================
    localparam logic [3:0] CODE_PRC   = 4'h2;
    localparam logic [3:0] CODE_SSUT  = 4'h4;
    localparam logic [3:0] CODE_SSUL  = 4'h8;
    localparam logic [3:0] CODE_SEC   = 4'hB;
    localparam logic [3:0] CODE_DNU   = 4'hF;
    localparam logic [3:0] CODE_RESET = 4'hF;

    // ==========================================================
    // Quality levels
    // ==========================================================
    typedef enum logic [2:0] {
        QL_PRC,
        QL_SSUT,
        QL_SSUL,
        QL_SEC,
        QL_DNU,
        QL_NOT_SUPPORTED
    } scss_ql_t;

    // Unknown codes are treated as do-not-use, the safe choice.
    function automatic scss_ql_t scss_code_to_ql(input logic [3:0] code);
        scss_ql_t ql;
        ql = QL_DNU;
        case (code)
            CODE_PRC:  ql = QL_PRC;
            CODE_SSUT: ql = QL_SSUT;
            CODE_SSUL: ql = QL_SSUL;
            CODE_SEC:  ql = QL_SEC;
            default:   ql = QL_DNU;
        endcase
        return ql;
    endfunction

endpackage

// File: design/scss_station_clock_sink.sv
`timescale 1ns/100ps
module scss_station_clock_sink
    import scss_pkg::*;
#(
    parameter int CSID_W = 8
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              link_clk_i,
    input  wire logic              link_data_i,
    input  wire logic              link_frame_start_i,
    input  wire logic              link_mframe_start_i,
    input  wire logic              trail_signal_fail_in_i,
    input  wire logic              multiframe_present_in_i,
    input  wire logic              quality_mode_enable_i,
    input  wire logic              status_msg_support_i,
    input  wire logic [3:0]        spare_bit_select_i,
    input  wire logic [CSID_W-1:0] own_source_identifier_i,
    input  wire logic [CSID_W-1:0] remote_source_identifier_in_i,
    input  wire scss_ql_t          remote_quality_in_i,
    output scss_ql_t               quality_level_out_o,
    output logic [CSID_W-1:0]      source_identifier_out_o,
    output logic                   server_fail_out_o,
    output logic                   timing_clock_out_o
);

    localparam logic [CSID_W-1:0] CSID_NONE = '0;

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic       en_m;
        logic       en_s;
        logic [3:0] sel_m;
        logic [3:0] sel_s;
        logic [3:0] sel_q;
        logic [7:0] bit_cnt;
        logic [3:0] frm;
        logic       aligned;
        logic [2:0] shift;
        logic [3:0] cand;
        logic [1:0] cnt;
        logic [3:0] acc;
        logic       tgl;
    } scss_link_t;

    typedef struct packed {
        logic              en;
        logic              tsf_m;
        logic              tsf_s;
        logic              mfp_m;
        logic              mfp_s;
        logic              tgl_m;
        logic              tgl_s;
        logic              tgl_d;
        logic [3:0]        code;
        scss_ql_t          ql;
        logic [CSID_W-1:0] cs;
        logic              ssf;
    } scss_sys_t;

    scss_link_t l_r;
    scss_link_t l_nxt;
    scss_sys_t  s_r;
    scss_sys_t  s_nxt;
    logic       lrst_m_r;
    logic       lrst_n_r;
    logic [3:0] frm_cur;
    logic [7:0] pos;
    logic       take;
    logic [3:0] code_rx;

    // ==========================================================
    // Link domain
    // ==========================================================
    // Reset is brought into the link domain through two stages.
    always_ff @(posedge link_clk_i) begin
        lrst_m_r <= rst_n_i;
        lrst_n_r <= lrst_m_r;
    end

    // Frame position tracking, spare bit sampling and acceptance.
    always_comb begin
        l_nxt   = l_r;
        l_nxt.en_m  = s_r.en;
        l_nxt.en_s  = l_r.en_m;
        // The select is quasi-static; a third stage must agree with the
        // second, so a value caught half-changed is never used.
        l_nxt.sel_m = spare_bit_select_i;
        l_nxt.sel_s = l_r.sel_m;
        l_nxt.sel_q = l_r.sel_s;
        frm_cur = l_r.frm;
        pos     = l_r.bit_cnt;
        if (link_frame_start_i) begin
            pos     = 8'h00;
            frm_cur = link_mframe_start_i ? 4'h0 : l_r.frm + 4'h1;
        end
        l_nxt.bit_cnt = pos + 8'h01;
        l_nxt.frm     = frm_cur;
        if (link_frame_start_i && link_mframe_start_i) begin
            l_nxt.aligned = 1'b1;
        end
        // Odd frames carry the spare bits; four make one code.
        take = l_r.en_s && l_nxt.aligned && frm_cur[0]
            && l_r.sel_q == l_r.sel_s
            && l_r.sel_q >= SPARE_BIT_MIN && l_r.sel_q <= SPARE_BIT_MAX
            && pos == {4'h0, l_r.sel_q - SPARE_BIT_OFS};
        code_rx = {l_r.shift, link_data_i};
        if (!l_r.en_s) begin
            l_nxt.cnt = 2'h0;
        end else if (take) begin
            if (frm_cur[2:1] != LAST_CODE_BIT) begin
                l_nxt.shift = {l_r.shift[1:0], link_data_i};
            end else begin
                l_nxt.cand = code_rx;
                if (code_rx != l_r.cand || l_r.cnt == 2'h0) begin
                    l_nxt.cnt = 2'h1;
                end else if (l_r.cnt != ACCEPT_COUNT) begin
                    l_nxt.cnt = l_r.cnt + 2'h1;
                end
                if (l_nxt.cnt == ACCEPT_COUNT && l_r.acc != code_rx) begin
                    l_nxt.acc = code_rx;
                    l_nxt.tgl = ~l_r.tgl;
                end
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n_r) begin
            l_r     <= '0;
            l_r.acc <= CODE_RESET;
        end else begin
            l_r <= l_nxt;
        end
    end

    // ==========================================================
    // System domain
    // ==========================================================
    // The accepted code is held stable while its toggle crosses over.
    always_comb begin
        s_nxt       = s_r;
        s_nxt.en    = quality_mode_enable_i && status_msg_support_i;
        s_nxt.tsf_m = trail_signal_fail_in_i;
        s_nxt.tsf_s = s_r.tsf_m;
        s_nxt.mfp_m = multiframe_present_in_i;
        s_nxt.mfp_s = s_r.mfp_m;
        s_nxt.tgl_m = l_r.tgl;
        s_nxt.tgl_s = s_r.tgl_m;
        s_nxt.tgl_d = s_r.tgl_s;
        if (s_r.tgl_s != s_r.tgl_d) begin
            s_nxt.code = l_r.acc;
        end
        if (quality_mode_enable_i && status_msg_support_i) begin
            s_nxt.ql = scss_code_to_ql(s_r.code);
        end else begin
            s_nxt.ql = QL_NOT_SUPPORTED;
        end
        if (remote_source_identifier_in_i == CSID_NONE) begin
            s_nxt.cs = own_source_identifier_i;
        end else if (quality_mode_enable_i && status_msg_support_i) begin
            if (remote_quality_in_i == s_r.ql
                || remote_quality_in_i == QL_NOT_SUPPORTED) begin
                s_nxt.cs = remote_source_identifier_in_i;
            end else begin
                s_nxt.cs = own_source_identifier_i;
            end
        end else begin
            s_nxt.cs = remote_source_identifier_in_i;
        end
        s_nxt.ssf = s_r.tsf_s || (!s_r.mfp_s && s_r.en);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s_r      <= '0;
            s_r.code <= CODE_RESET;
            s_r.ql   <= QL_NOT_SUPPORTED;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; the clock passes straight through, no regeneration here.
    assign quality_level_out_o     = s_r.ql;
    assign source_identifier_out_o = s_r.cs;
    assign server_fail_out_o       = s_r.ssf;
    assign timing_clock_out_o      = link_clk_i;

    // ==========================================================
    // Assertions
    // ==========================================================
    property p_sel_range;
        @(posedge link_clk_i) disable iff (!lrst_n_r)
        take |-> l_r.sel_q >= 4'h4 && l_r.sel_q <= 4'h8
            && pos == {4'h0, l_r.sel_q} - 8'h01;
    endproperty
    a_sel_range: assert property (p_sel_range)
        else $error("spare bit sampled outside selected range");

    property p_no_recover;
        @(posedge link_clk_i) disable iff (!lrst_n_r)
        !l_r.en_s |=> l_r.cnt == 2'h0 && $stable(l_r.acc);
    endproperty
    a_no_recover: assert property (p_no_recover)
        else $error("code recovered while disabled");

    property p_accept_three;
        @(posedge link_clk_i) disable iff (!lrst_n_r)
        !$stable(l_r.acc) |-> l_r.cnt == 2'h3 && $past(l_r.cnt) == 2'h2
            && l_r.acc == l_r.cand;
    endproperty
    a_accept_three: assert property (p_accept_three)
        else $error("code accepted without three equal receptions");

    property p_align;
        @(posedge link_clk_i) disable iff (!lrst_n_r)
        link_frame_start_i && link_mframe_start_i
            |=> l_r.aligned && l_r.frm == 4'h0 && l_r.bit_cnt == 8'h01;
    endproperty
    a_align: assert property (p_align)
        else $error("spare bit sampled out of alignment");

    property p_ql_map;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        quality_mode_enable_i && status_msg_support_i
            |=> quality_level_out_o == scss_code_to_ql($past(s_r.code));
    endproperty
    a_ql_map: assert property (p_ql_map)
        else $error("quality level does not follow accepted code");

    property p_qmode_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !quality_mode_enable_i |=> quality_level_out_o == QL_NOT_SUPPORTED;
    endproperty
    a_qmode_off: assert property (p_qmode_off)
        else $error("quality shown with quality mode off");

    property p_support_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !status_msg_support_i |=> quality_level_out_o == QL_NOT_SUPPORTED;
    endproperty
    a_support_off: assert property (p_support_off)
        else $error("quality shown with support off");

    property p_cs_none;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        remote_source_identifier_in_i == '0
            |=> source_identifier_out_o == $past(own_source_identifier_i);
    endproperty
    a_cs_none: assert property (p_cs_none)
        else $error("own identifier not used without remote one");

    property p_cs_mismatch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        remote_source_identifier_in_i != '0 && quality_mode_enable_i
            && status_msg_support_i && remote_quality_in_i != s_r.ql
            && remote_quality_in_i != QL_NOT_SUPPORTED
            |=> source_identifier_out_o == $past(own_source_identifier_i);
    endproperty
    a_cs_mismatch: assert property (p_cs_mismatch)
        else $error("remote identifier passed with disagreeing quality");

    property p_ssf;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        trail_signal_fail_in_i [*3] |=> server_fail_out_o;
    endproperty
    a_ssf: assert property (p_ssf)
        else $error("server fail missing during trail fail");

    c_accept: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.tgl_s != s_r.tgl_d);
    c_fail: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(server_fail_out_o));
    c_own_cs: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        remote_source_identifier_in_i != '0
        && source_identifier_out_o == own_source_identifier_i);

endmodule // scss_station_clock_sink

// File: verif/scss_link_model.sv
`timescale 1ns/100ps
// ==========================================================
// Framer model of the line side
// ==========================================================
module scss_link_model (
    input  wire logic [3:0] code_i,
    input  wire logic [3:0] sel_i,
    output logic            clk_o,
    output logic            data_o,
    output logic            fs_o,
    output logic            mfs_o,
    output logic            smf_o
);
    logic [7:0] bit_r = 8'h00;
    logic [3:0] frm_r = 4'h0;
    logic       cbit;

    // A recovered line clock runs free, also between frames.
    initial begin
        clk_o = 1'b0;
        forever #3 clk_o = ~clk_o;
    end

    // Frames of 256 bits, 16 frames to a multiframe.
    always_ff @(posedge clk_o) begin
        bit_r <= bit_r + 8'h01;
        if (bit_r == 8'hFF) frm_r <= frm_r + 4'h1;
    end

    // Markers come with the first bit of a frame and of a multiframe.
    assign fs_o  = (bit_r == 8'h00);
    assign mfs_o = fs_o && (frm_r == 4'h0);
    assign smf_o = fs_o && (frm_r[2:0] == 3'h0);
    // Odd frames carry the code, most significant bit first.
    assign cbit  = code_i[2'h3 - frm_r[2:1]];
    // Other places carry the inverse, so a wrong pick is seen.
    assign data_o = (frm_r[0] && bit_r == {4'h0, sel_i - 4'h1}) ? cbit
                                                               : ~cbit;
endmodule // scss_link_model

// File: verif/station_clock_ssm_sink_test.sv
`timescale 1ns/100ps
module station_clock_ssm_sink_test
    import scss_pkg::*;
;
    logic       clk_sys_i, rst_n_i, tsf, mfp, qmode, supp;
    logic [3:0] sel, code;
    logic [7:0] own, rcs, cs;
    scss_ql_t   rq, ql;
    logic       ssf, tclk, lclk, ldat, lfs, lmfs, smf;
    int         failures, num_checks;
    logic [3:0] code_tab [6] = '{4'h2, 4'h4, 4'h1, 4'h8, 4'hB, 4'hF};
    scss_ql_t   ql_tab [6] = '{QL_PRC, QL_SSUT, QL_DNU, QL_SSUL, QL_SEC,
                               QL_DNU};

    // ==========================================================
    // Block, line model and clock
    // ==========================================================
    scss_station_clock_sink uut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(lclk),
        .link_data_i(ldat), .link_frame_start_i(lfs),
        .link_mframe_start_i(lmfs), .trail_signal_fail_in_i(tsf),
        .multiframe_present_in_i(mfp), .quality_mode_enable_i(qmode),
        .status_msg_support_i(supp), .spare_bit_select_i(sel),
        .own_source_identifier_i(own),
        .remote_source_identifier_in_i(rcs), .remote_quality_in_i(rq),
        .quality_level_out_o(ql), .source_identifier_out_o(cs),
        .server_fail_out_o(ssf), .timing_clock_out_o(tclk));
    scss_link_model line (.code_i(code), .sel_i(sel), .clk_o(lclk),
        .data_o(ldat), .fs_o(lfs), .mfs_o(lmfs), .smf_o(smf));

    // The system clock runs at 125 MHz.
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Every output has settled well within five system cycles.
    task automatic settle();
        repeat (5) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Reset is held two cycles; the line side has two edges of it.
    task automatic t_reset();
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        check(8'(ql), 8'(QL_NOT_SUPPORTED));
        check(cs, 8'h00);
        check(8'(ssf), 8'h00);
        repeat (3) @(posedge clk_sys_i);
        #1;
        check(cs, 8'hA5);
        $display("test reset done");
    endtask

    task automatic t_ssf();
        @(posedge clk_sys_i); tsf <= 1'b1;
        settle(); check(8'(ssf), 8'h01);
        @(posedge clk_sys_i); tsf <= 1'b0; mfp <= 1'b0;
        settle(); check(8'(ssf), 8'h01);
        @(posedge clk_sys_i); qmode <= 1'b0;
        settle(); check(8'(ssf), 8'h00);
        @(posedge clk_sys_i); qmode <= 1'b1; mfp <= 1'b1;
        settle(); check(8'(ssf), 8'h00);
        // Off-grid sample times never meet a line clock edge.
        #0.5;
        repeat (3) begin
            check(8'(tclk), 8'(lclk));
            #1;
        end
        $display("test server fail done");
    endtask

    task automatic t_modes();
        @(posedge clk_sys_i); qmode <= 1'b0;
        settle(); check(8'(ql), 8'(QL_NOT_SUPPORTED));
        @(posedge clk_sys_i); qmode <= 1'b1; supp <= 1'b0;
        settle(); check(8'(ql), 8'(QL_NOT_SUPPORTED));
        @(posedge clk_sys_i); supp <= 1'b1;
        settle(); check(8'(ql), 8'(QL_DNU));
        $display("test modes done");
    endtask

    task automatic t_csid();
        settle(); check(cs, 8'hA5);
        @(posedge clk_sys_i); rcs <= 8'h3C; rq <= QL_DNU;
        settle(); check(cs, 8'h3C);
        @(posedge clk_sys_i); rq <= QL_NOT_SUPPORTED;
        settle(); check(cs, 8'h3C);
        @(posedge clk_sys_i); rq <= QL_PRC;
        settle(); check(cs, 8'hA5);
        @(posedge clk_sys_i); supp <= 1'b0;
        settle(); check(cs, 8'h3C);
        @(posedge clk_sys_i); supp <= 1'b1; rcs <= 8'h00;
        $display("test identifier done");
    endtask

    // Each code changes at a submultiframe start, one Sa bit each.
    task automatic t_codes();
        scss_ql_t prev;
        @(posedge lmfs);
        for (int i = 0; i < 6; i++) begin
            @(posedge smf);
            @(posedge clk_sys_i);
            code <= code_tab[i];
            sel  <= 4'h4 + 4'(i % 5);
            prev = (i == 0) ? QL_DNU : ql_tab[i-1];
            repeat (2) @(posedge smf);
            settle(); check(8'(ql), 8'(prev));
            @(posedge smf);
            repeat (2) settle();
            check(8'(ql), 8'(ql_tab[i]));
        end
        $display("test codes done");
    endtask

    task automatic t_refuse();
        @(posedge smf);
        @(posedge clk_sys_i); sel <= 4'h3; code <= 4'h2;
        repeat (4) @(posedge smf);
        settle(); check(8'(ql), 8'(QL_DNU));
        // With support off the same code must not be recovered.
        @(posedge clk_sys_i); sel <= 4'h4; supp <= 1'b0;
        repeat (4) @(posedge smf);
        settle(); check(8'(ql), 8'(QL_NOT_SUPPORTED));
        @(posedge clk_sys_i); supp <= 1'b1;
        settle(); check(8'(ql), 8'(QL_DNU));
        $display("test refuse done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        rst_n_i = 1'b0; tsf = 1'b0; mfp = 1'b1; qmode = 1'b1; supp = 1'b1;
        sel = 4'h4; code = 4'hF; own = 8'hA5; rcs = 8'h00; rq = QL_DNU;
        failures = 0; num_checks = 0;
        t_reset();
        t_ssf();
        t_modes();
        t_csid();
        t_codes();
        t_refuse();
        summarize();
    end

    // The scenarios need about 0.45 ms; the limit is 75000 system cycles.
    initial begin
        #600000;
        failures++;
        summarize();
    end
endmodule // station_clock_ssm_sink_test
